// file: design/irmc_top.sv
// ingress rate meter config: wishbone register bank with indirect table access
//
// Register access over Wishbone was left to the implementer.
`include "irmc_defines.svh"
module irmc_top (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_b_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [`IRMC_ADR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    output logic                           wb_err_o,
    output logic                           meter_enable_o,
    output logic      [1:0]                meter_mode_o
);
    irmc_tbl_if tbl_bus ();

    logic                      en_q;
    logic [1:0]                mode_q;
    logic                      dir_q;
    logic [1:0]                sel_q;
    logic [`IRMC_IDX_W-1:0]    idx_q;
    logic [`IRMC_ENTRY_W-1:0]  wval_q;
    logic [`IRMC_ENTRY_W-1:0]  rval_q;
    logic                      pend_q;
    logic [1:0]                cnt_q;
    irmc_pkg::irmc_state_e     st_q;
    logic                      wb_ack_q;
    logic                      wb_err_q;
    logic [31:0]               wb_dat_q;
    logic                      req;
    logic                      hit;
    logic                      wr_cmd;
    logic                      wr_cfg;
    logic                      wr_wval;
    logic [31:0]               rd_mux;

    // a new request is one not yet answered; ack drops the cycle after it rises
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_q && !wb_err_q;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `IRMC_OFS_MODE_CFG:  rd_mux = {29'h0, mode_q, en_q};
            `IRMC_OFS_TABLE_CMD: rd_mux = {24'h0, dir_q, sel_q, idx_q};
            `IRMC_OFS_TABLE_STS: rd_mux = {31'h0, pend_q}; // RULE13
            `IRMC_OFS_WR_VALUE:  rd_mux = {16'h0, wval_q}; // RULE16
            `IRMC_OFS_RD_VALUE:  rd_mux = {16'h0, rval_q}; // RULE16
            default:             hit = 1'b0;
        endcase
    end

    // config and command writes need byte lane 0; the write value takes bits 7:0 on lane 0 and bits 15:8 on lane 1
    assign wr_cfg  = req && hit && wb_we_i && wb_adr_i == `IRMC_OFS_MODE_CFG && wb_sel_i[0];
    assign wr_cmd  = req && hit && wb_we_i && wb_adr_i == `IRMC_OFS_TABLE_CMD && wb_sel_i[0];
    assign wr_wval = req && hit && wb_we_i && wb_adr_i == `IRMC_OFS_WR_VALUE;

    // bus answer: one cycle after the request, err on unmapped address
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wb_ack_q <= 1'b0;
            wb_err_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= req && hit;
            wb_err_q <= req && !hit;
            wb_dat_q <= (req && hit && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // mode and enable; the reserved mode code is stored as written
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q   <= 1'b0;
            mode_q <= 2'h0;
        end else if (wr_cfg) begin
            en_q   <= wb_dat_i[`IRMC_CFG_EN_BIT]; // RULE2
            mode_q <= wb_dat_i[`IRMC_CFG_MODE_HI:`IRMC_CFG_MODE_LO]; // RULE1
        end
    end

    // write value register, honouring the two low byte lanes
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wval_q <= 16'h0000;
        end else if (wr_wval) begin
            if (wb_sel_i[0]) begin
                wval_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                wval_q[15:8] <= wb_dat_i[15:8]; // RULE16
            end
        end
    end

    // command fields; a command written while busy or done is dropped so the access in flight stays coherent
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_q <= 1'b0;
            sel_q <= 2'h0;
            idx_q <= 5'h00;
        end else if (wr_cmd && st_q == irmc_pkg::IRMC_ST_IDLE) begin
            dir_q <= wb_dat_i[`IRMC_CMD_DIR_BIT]; // RULE4
            sel_q <= wb_dat_i[`IRMC_CMD_SEL_HI:`IRMC_CMD_SEL_LO]; // RULE5
            idx_q <= wb_dat_i[`IRMC_CMD_IDX_HI:`IRMC_CMD_IDX_LO]; // RULE6
        end
    end

    // sequencer: idle -> busy for a fixed latency -> done, pending stays set through busy and done
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q   <= irmc_pkg::IRMC_ST_IDLE;
            cnt_q  <= 2'h0;
            pend_q <= 1'b0;
        end else begin
            case (st_q)
                irmc_pkg::IRMC_ST_IDLE: begin
                    if (wr_cmd) begin
                        st_q   <= irmc_pkg::IRMC_ST_BUSY; // RULE3
                        cnt_q  <= `IRMC_ACCESS_CYC;
                        pend_q <= 1'b1; // RULE13
                    end
                end
                irmc_pkg::IRMC_ST_BUSY: begin
                    cnt_q <= cnt_q - 2'h1;
                    if (cnt_q == 2'h1) begin
                        st_q <= irmc_pkg::IRMC_ST_DONE;
                    end
                end
                irmc_pkg::IRMC_ST_DONE: begin
                    st_q   <= irmc_pkg::IRMC_ST_IDLE;
                    pend_q <= 1'b0; // RULE13
                end
                default: begin
                    st_q   <= irmc_pkg::IRMC_ST_IDLE;
                    pend_q <= 1'b0;
                end
            endcase
        end
    end

    // table port: the access itself happens in the done state
    assign tbl_bus.sel   = sel_q;
    assign tbl_bus.idx   = idx_q; // RULE7 RULE8 RULE9
    assign tbl_bus.wdata = wval_q;
    assign tbl_bus.wr_en = st_q == irmc_pkg::IRMC_ST_DONE && !dir_q; // RULE4

    // read value capture; reserved select yields zero from the table
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rval_q <= 16'h0000;
        end else if (st_q == irmc_pkg::IRMC_ST_DONE && dir_q) begin
            rval_q <= tbl_bus.rdata; // RULE17
        end
    end

    irmc_table u_table (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .acc       (tbl_bus)
    );

    assign wb_dat_o       = wb_dat_q;
    assign wb_ack_o       = wb_ack_q;
    assign wb_err_o       = wb_err_q;
    assign meter_enable_o = en_q; // RULE2
    assign meter_mode_o   = mode_q; // RULE1
endmodule

// file: design/irmc_defines.svh
// offsets, field positions, reset values and timing counts of the ingress rate meter config block
// Summary of operation
// RULE1: the two-bit mode field selects buckets by port and priority (0), port only (1), priority only (2); 3 is reserved.
// RULE2: the enable bit turns metering, coloring and dropping on; clear means no metering at all.
// RULE3: every software write to the table command register launches the access that its fields describe; the code drops one written while pending is set.
// RULE4: the direction bit of the command means read when 1 and write when 0.
// RULE5: table select 0 is reserved, 1 picks the committed rate entry by index, 2 committed burst, 3 excess burst.
// RULE6: a five-bit entry index chooses one of the 24 committed rate entries.
// RULE7: in port-and-priority mode entries 0-7, 8-15 and 16-23 belong to ports 0, 1 and 2, priority 0 lowest.
// RULE8: in port-only mode entries 0, 1 and 2 belong to ports 0, 1 and 2.
// RULE9: in priority-only mode entry n belongs to priority n, up to 23.
// RULE10: software reads a table entry by writing the command, waiting for pending to clear, then reading the result.
// RULE11: software loads the write value before the command and then watches pending for completion.
// RULE12: software keeps the entry index in range for the mode; out-of-range indices are undefined.
// RULE13: the pending bit stays set while an access runs and clears by itself when it finishes.
// RULE14: a committed rate entry gives time per byte as (value + 1) times 20 ns, default 0x0014.
// RULE15: the burst entries hold maximum burst sizes in bytes, default 0x0600.
// RULE16: read and write value registers carry the entry in bits 15:0, upper bits reserved.
// RULE17: a command with the reserved table type completes without changing any entry and reads back zero.
`ifndef IRMC_DEFINES_SVH
`define IRMC_DEFINES_SVH

`define IRMC_ADR_W          16
`define IRMC_OFS_MODE_CFG   16'h184a
`define IRMC_OFS_TABLE_CMD  16'h184b
`define IRMC_OFS_TABLE_STS  16'h184c
`define IRMC_OFS_WR_VALUE   16'h184d
`define IRMC_OFS_RD_VALUE   16'h184e

`define IRMC_CFG_EN_BIT     0
`define IRMC_CFG_MODE_HI    2
`define IRMC_CFG_MODE_LO    1
`define IRMC_CMD_DIR_BIT    7
`define IRMC_CMD_SEL_HI     6
`define IRMC_CMD_SEL_LO     5
`define IRMC_CMD_IDX_HI     4
`define IRMC_CMD_IDX_LO     0
`define IRMC_STS_PEND_BIT   0

`define IRMC_ENTRY_W        16
`define IRMC_NUM_CRE        24
`define IRMC_IDX_W          5
`define IRMC_CRE_RESET      16'h0014
`define IRMC_BURST_RESET    16'h0600
`define IRMC_RATE_UNIT_NS   20
`define IRMC_CLK_NS         20
// cycles per rate unit, worked out from the rate unit and the clock period
`define IRMC_RATE_UNIT_CYC  (`IRMC_RATE_UNIT_NS / `IRMC_CLK_NS)
// table access latency in cycles once launched
`define IRMC_ACCESS_CYC     2'h2

`endif

// file: design/irmc_pkg.sv
// types shared by the ingress rate meter config block
package irmc_pkg;
    typedef enum logic [1:0] {
        IRMC_MODE_PORT_PRIO,
        IRMC_MODE_PORT,
        IRMC_MODE_PRIO,
        IRMC_MODE_RSVD
    } irmc_mode_e;

    typedef enum logic [1:0] {
        IRMC_SEL_RSVD,
        IRMC_SEL_CRE,
        IRMC_SEL_CBS,
        IRMC_SEL_EBS
    } irmc_sel_e;

    typedef enum logic [1:0] {
        IRMC_ST_IDLE,
        IRMC_ST_BUSY,
        IRMC_ST_DONE
    } irmc_state_e;

    typedef logic [15:0] irmc_entry_t;
endpackage

// file: design/irmc_tbl_if.sv
// access port between the command sequencer and the metering table
`include "irmc_defines.svh"
interface irmc_tbl_if;
    logic                      wr_en;
    logic [1:0]                sel;
    logic [`IRMC_IDX_W-1:0]    idx;
    logic [`IRMC_ENTRY_W-1:0]  wdata;
    logic [`IRMC_ENTRY_W-1:0]  rdata;

    modport seq (output wr_en, output sel, output idx, output wdata, input rdata);
    modport tbl (input wr_en, input sel, input idx, input wdata, output rdata);
endinterface

// file: design/irmc_table.sv
// metering table storage: committed rate entries and the two burst entries
`include "irmc_defines.svh"
module irmc_table (
    input  wire logic      clk_sys_i,
    input  wire logic      rst_b_i,
    irmc_tbl_if.tbl        acc
);
    logic [`IRMC_ENTRY_W-1:0] cre_q [`IRMC_NUM_CRE];
    logic [`IRMC_ENTRY_W-1:0] cbs_q;
    logic [`IRMC_ENTRY_W-1:0] ebs_q;

    // one flop group per committed rate entry
    genvar gi;
    generate
        for (gi = 0; gi < `IRMC_NUM_CRE; gi++) begin : g_cre
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cre_q[gi] <= `IRMC_CRE_RESET; // RULE14
                end else if (acc.wr_en && acc.sel == irmc_pkg::IRMC_SEL_CRE
                             && acc.idx == `IRMC_IDX_W'(gi)) begin
                    cre_q[gi] <= acc.wdata; // RULE6
                end
            end
        end
    endgenerate

    // burst entries; reserved select writes nothing
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cbs_q <= `IRMC_BURST_RESET; // RULE15
            ebs_q <= `IRMC_BURST_RESET; // RULE15
        end else if (acc.wr_en) begin
            if (acc.sel == irmc_pkg::IRMC_SEL_CBS) begin
                cbs_q <= acc.wdata;
            end
            if (acc.sel == irmc_pkg::IRMC_SEL_EBS) begin
                ebs_q <= acc.wdata;
            end
        end
    end

    // read mux; out-of-range index reads zero, reserved select reads zero
    always_comb begin
        acc.rdata = '0;
        case (acc.sel)
            irmc_pkg::IRMC_SEL_CRE: begin
                if (acc.idx < `IRMC_IDX_W'(`IRMC_NUM_CRE)) begin
                    acc.rdata = cre_q[acc.idx]; // RULE6
                end
            end
            irmc_pkg::IRMC_SEL_CBS: acc.rdata = cbs_q; // RULE5
            irmc_pkg::IRMC_SEL_EBS: acc.rdata = ebs_q; // RULE5
            default: acc.rdata = '0; // RULE17
        endcase
    end
endmodule

// file: dv/irmc_chk.sv
// assertion checker for the ingress rate meter config register port
`include "irmc_defines.svh"
module irmc_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        meter_enable_o,
    input wire logic [1:0]  meter_mode_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic       tk, mp, cfg_wr, sts_rd;
    logic [3:0] since_cmd_q;
    // request taken at this edge, and whether it hits a mapped register
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mp = wb_adr_i >= `IRMC_OFS_MODE_CFG && wb_adr_i <= `IRMC_OFS_RD_VALUE;
    assign cfg_wr = tk && wb_we_i && wb_sel_i[0] && wb_adr_i == `IRMC_OFS_MODE_CFG;
    assign sts_rd = tk && !wb_we_i && wb_adr_i == `IRMC_OFS_TABLE_STS;
    // cycles since an accepted command; a command while pending is ignored, so it must not restart the count
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_cmd_q <= 4'hf;
        end else if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == `IRMC_OFS_TABLE_CMD && since_cmd_q > 4'h2) begin
            since_cmd_q <= 4'h0;
        end else if (since_cmd_q != 4'hf) begin
            since_cmd_q <= since_cmd_q + 4'h1;
        end
    end
    a_ack_after_take: assert property (tk && mp |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acked in the next cycle");
    a_err_unmapped: assert property (tk && !mp |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused with err");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data driven without ack");
    a_enable_set: assert property (cfg_wr |=> ##1 meter_enable_o == $past(wb_dat_i[0], 2))
        else $error("metering enable does not follow the written bit");
    a_mode_set: assert property (cfg_wr |=> ##1 meter_mode_o == $past(wb_dat_i[2:1], 2))
        else $error("metering mode does not follow the written field");
    a_cfg_readback: assert property (tk && !wb_we_i && wb_adr_i == `IRMC_OFS_MODE_CFG
        |=> wb_dat_o == {29'h0, meter_mode_o, meter_enable_o})
        else $error("mode register readback differs from outputs");
    a_pending_held: assert property (sts_rd && since_cmd_q <= 4'h2 |=> wb_dat_o == 32'h1)
        else $error("pending not shown while access runs");
    a_pending_clear: assert property (sts_rd && since_cmd_q > 4'h2 |=> wb_dat_o == 32'h0)
        else $error("pending not cleared after access");
    c_cmd: cover property (sts_rd && since_cmd_q == 4'h2);
    c_err: cover property (wb_err_o);
    c_mode3: cover property (meter_mode_o == 2'h3);
endmodule
bind irmc_top irmc_chk u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .meter_enable_o(meter_enable_o), .meter_mode_o(meter_mode_o));

// file: dv/ingress_rate_meter_config_tb_top.sv
// self-checking bench for the ingress rate meter config register bank
`include "irmc_defines.svh"
module ingress_rate_meter_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [15:0] adr = 16'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic        ack, err, en, rerr;
    logic [1:0]  mode;
    int          failures = 0, n_tests = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    irmc_top dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .meter_enable_o(en), .meter_mode_o(mode));
    // one classic cycle; holds the request until ack or err is sampled high
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_sys_i);
        while (ack !== 1'b1 && err !== 1'b1) begin
            @(posedge clk_sys_i);
        end
        rdat = dat_o;
        rerr = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // launch a table access, see pending set, then poll a bounded number of times until it drops
    task automatic cmd(input logic dir, input logic [1:0] s, input logic [4:0] i);
        int n;
        n = 0;
        xfer(1'b1, `IRMC_OFS_TABLE_CMD, {24'h0, dir, s, i});
        rd(`IRMC_OFS_TABLE_STS, 32'h1);
        while (rdat[0] !== 1'b0 && n < 10) begin
            xfer(1'b0, `IRMC_OFS_TABLE_STS, 32'h0);
            n++;
        end
        chk(rdat, 32'h0);
    endtask
    task automatic entry(input logic [1:0] s, input logic [4:0] i, input logic [15:0] exp);
        cmd(1'b1, s, i);
        rd(`IRMC_OFS_RD_VALUE, {16'h0, exp});
    endtask
    // upper bits set on purpose: they must not reach the entry
    task automatic put(input logic [1:0] s, input logic [4:0] i, input logic [15:0] v);
        xfer(1'b1, `IRMC_OFS_WR_VALUE, {16'hffff, v});
        cmd(1'b0, s, i);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog well beyond the roughly 800 cycles the sequence needs
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        failures++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(`IRMC_OFS_MODE_CFG, 32'h0);
        rd(`IRMC_OFS_WR_VALUE, 32'h0);
        rd(`IRMC_OFS_RD_VALUE, 32'h0);
        xfer(1'b0, 16'h1849, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset_values done");
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, `IRMC_OFS_MODE_CFG, {29'h0, m[1:0], m[0]});
            chk({29'h0, mode, en}, {29'h0, m[1:0], m[0]});
            rd(`IRMC_OFS_MODE_CFG, {29'h0, m[1:0], m[0]});
        end
        $display("test modes done");
        entry(irmc_pkg::IRMC_SEL_CRE, 5'h0, 16'h0014);
        entry(irmc_pkg::IRMC_SEL_CRE, 5'h17, 16'h0014);
        entry(irmc_pkg::IRMC_SEL_CBS, 5'h0, 16'h0600);
        entry(irmc_pkg::IRMC_SEL_EBS, 5'h0, 16'h0600);
        $display("test defaults done");
        for (int i = 0; i < 24; i++) begin
            put(irmc_pkg::IRMC_SEL_CRE, i[4:0], 16'ha500 + i[15:0]);
        end
        put(irmc_pkg::IRMC_SEL_CBS, 5'h0, 16'h1234);
        put(irmc_pkg::IRMC_SEL_EBS, 5'h0, 16'h4321);
        for (int i = 0; i < 24; i++) begin
            entry(irmc_pkg::IRMC_SEL_CRE, i[4:0], 16'ha500 + i[15:0]);
        end
        entry(irmc_pkg::IRMC_SEL_CBS, 5'h0, 16'h1234);
        entry(irmc_pkg::IRMC_SEL_EBS, 5'h0, 16'h4321);
        $display("test table_access done");
        put(irmc_pkg::IRMC_SEL_RSVD, 5'h0, 16'hbeef);
        rd(`IRMC_OFS_WR_VALUE, 32'h0000beef);
        entry(irmc_pkg::IRMC_SEL_RSVD, 5'h0, 16'h0);
        entry(irmc_pkg::IRMC_SEL_CBS, 5'h0, 16'h1234);
        entry(irmc_pkg::IRMC_SEL_CRE, 5'h0, 16'ha500);
        $display("test reserved_type done");
        // a command taken while one is in flight is dropped; the register keeps the accepted one
        xfer(1'b1, `IRMC_OFS_TABLE_CMD, 32'h0000_00c0);
        xfer(1'b1, `IRMC_OFS_TABLE_CMD, 32'h0000_0060);
        rd(`IRMC_OFS_TABLE_CMD, 32'h0000_00c0);
        rd(`IRMC_OFS_TABLE_STS, 32'h0000_0000);
        rd(`IRMC_OFS_RD_VALUE, 32'h0000_1234);
        entry(irmc_pkg::IRMC_SEL_EBS, 5'h0, 16'h4321);
        // config write without byte lane 0 must leave mode and enable alone
        sel <= 4'he;
        xfer(1'b1, `IRMC_OFS_MODE_CFG, 32'h0000_0000);
        chk({30'h0, mode}, 32'h0000_0003);
        chk({31'h0, en}, 32'h0000_0001);
        sel <= 4'hf;
        $display("test refused done");
        end_sim();
    end
endmodule
